// ---- design/tsi_pkg.sv ----
/*
 Constants and states for the temperature sensor two-wire slave.
 Assumes one 200 MHz system clock; bus lines and strap pins are asynchronous.
*/
// How it works
// - Result register holds the latest conversion; the bus only reads it.
// - A result read is two bytes; twelve temperature bits, rest zero.
// - Two's complement sixteenths of a degree; out of range saturates at 7FF or 800.
// - After reset the result reads zero until the first conversion completes.
// - At 9, 10 or 11 bits resolution, unused low bits are forced to zero.
// - Selector 00..11 gives 9..12 bits, typically 27.5 to 220 ms per conversion.
// - Slave only; every byte shifts most significant bit first.
// - Supports fast mode to 400 kHz and high-speed mode to 2 MHz.
// - Data falling while clock is high is START, beginning a transfer.
// - Seven address bits plus direction; the addressed slave acks on pulse nine.
// - Bytes are eight pulses plus ack; data changes while clock high are conditions.
// - Data rising while clock is high is STOP, ending the transfer.
// - Three-level variant: low, high or floating pins give 27 addresses.
// - Two-level variant: pins form low three bits under prefix 1001.
// - Select pins sampled after reset, at each start, and on acquire requests.
// - First byte after a write address loads the pointer register.
// - Reads use the last written pointer, which reads never change.
// - Two-byte registers go out high byte first, then low byte.
// - Data bytes after the pointer are acked and then discarded; no register is written.
// - Master ends a read by nack, START or STOP; device releases data.
// - Short spikes on both bus lines are filtered before the protocol logic.
package tsi_pkg;
    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int MCLK_MHZ  = 200;
    localparam int SPIKE_NS  = 10;
    localparam int FILT_CYC  = (SPIKE_NS * MCLK_MHZ + 999) / 1000;
    localparam logic [17:0] TCONV9_US  = 18'h06B6C;
    localparam logic [17:0] TCONV10_US = 18'h0D6D8;
    localparam logic [17:0] TCONV11_US = 18'h1ADB0;
    localparam logic [17:0] TCONV12_US = 18'h35B60;
    // ***************************************************************
    // Registers and values
    // ***************************************************************
    localparam logic [7:0]  PTR_TEMP   = 8'h00;
    localparam logic [7:0]  PTR_RST    = 8'h00;
    localparam logic [11:0] TEMP_RST   = 12'h000;
    localparam logic [11:0] TEMP_MAX   = 12'h7FF;
    localparam logic [11:0] TEMP_MIN   = 12'h800;
    localparam logic [1:0]  LVL_LOW    = 2'h0;
    localparam logic [1:0]  LVL_FLOAT  = 2'h2;
    localparam logic [3:0]  ADDR_PFX2  = 4'h9;
    localparam logic [3:0]  ADDR_TOPF  = 4'hE;
    localparam logic [4:0]  ADDR_MIDF  = 5'h0A;
    localparam logic [4:0]  ADDR_LOWF  = 5'h0B;
    localparam logic [6:0]  ADDR_MLF   = 7'h35;
    localparam logic [6:0]  ADDR_ALLF  = 7'h37;

    typedef enum logic [2:0] {
        TSI_IDLE   = 3'b000,
        TSI_ADDR   = 3'b001,
        TSI_ACK_AD = 3'b010,
        TSI_WR     = 3'b011,
        TSI_ACK_WR = 3'b100,
        TSI_RD     = 3'b101,
        TSI_MACK   = 3'b110
    } tsi_state_t;
endpackage

// ---- design/tsi_slave.sv ----
/*
 Two-wire slave of a digital temperature sensor: spike filter, condition
 detection, address strap decode, pointer register and result read-out.
 Assumes an external master owns SCL; SDA is open drain, resolved outside.
 Conversion logic on mclk supplies results and a done pulse.
*/
module tsi_slave #(
    parameter bit THREE_LEVEL = 1'b1
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Address straps: 0 low, 1 high, 2 or 3 floating
    input  wire logic [1:0]  addr_select_pin_low,
    input  wire logic [1:0]  addr_select_pin_mid,
    input  wire logic [1:0]  addr_select_pin_high,
    input  wire logic        addr_acquire_req,
    // Conversion side
    input  wire logic        resolution_sel_upper,
    input  wire logic        resolution_sel_lower,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data,
    output logic [17:0]      conv_time_us,
    output logic [11:0]      temp_result,
    output logic [7:0]       reg_pointer,
    output logic [6:0]       slave_addr
);
    // ***************************************************************
    // Helpers
    // ***************************************************************
    function automatic logic is_f(input logic [1:0] v);
        return v[1];
    endfunction

    function automatic logic [6:0] addr_of(input logic [1:0] h, input logic [1:0] m, input logic [1:0] l);
        logic [2:0] idx = 3'h0;
        if (!THREE_LEVEL || !(is_f(h) || is_f(m) || is_f(l)))
            return {tsi_pkg::ADDR_PFX2, h[0], m[0], l[0]};
        if (is_f(h)) begin
            if (is_f(m) && is_f(l))
                return tsi_pkg::ADDR_ALLF;
            if (is_f(m))
                idx = 3'h6 + {2'h0, l[0]};
            else
                idx = (m[0] ? 3'h3 : 3'h0) + (is_f(l) ? 3'h1 : (l[0] ? 3'h2 : 3'h0));
            return {tsi_pkg::ADDR_TOPF, idx};
        end
        if (is_f(m) && is_f(l))
            return tsi_pkg::ADDR_MLF + {6'h0, h[0]};
        if (is_f(m))
            return {tsi_pkg::ADDR_MIDF, h[0], l[0]};
        return {tsi_pkg::ADDR_LOWF, h[0], m[0]};
    endfunction

    function automatic logic [11:0] res_mask(input logic [1:0] r);
        case (r)
            2'b00:   return 12'hFF8;
            2'b01:   return 12'hFFC;
            2'b10:   return 12'hFFE;
            default: return 12'hFFF;
        endcase
    endfunction

    // ***************************************************************
    // Synchronisers and spike filter
    // ***************************************************************
    logic [7:0] s1_ff, s2_ff;
    logic [1:0] filt_ff, nxt_filt;
    logic [1:0] fcnt_ff [2];
    logic [1:0] nxt_fcnt [2];
    logic [1:0] prev_ff;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            nxt_filt[i] = filt_ff[i];
            nxt_fcnt[i] = 2'h0;
            if (s2_ff[7-i] != filt_ff[i]) begin
                if (fcnt_ff[i] >= 2'(tsi_pkg::FILT_CYC - 1))
                    nxt_filt[i] = s2_ff[7-i];
                else
                    nxt_fcnt[i] = fcnt_ff[i] + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_ff      <= 8'hC0;
            s2_ff      <= 8'hC0;
            filt_ff    <= 2'h3;
            prev_ff    <= 2'h3;
            fcnt_ff    <= '{2'h0, 2'h0};
        end else begin
            s1_ff      <= {scl_i, sda_i, addr_select_pin_high, addr_select_pin_mid, addr_select_pin_low};
            s2_ff      <= s1_ff;
            filt_ff    <= nxt_filt;
            prev_ff    <= filt_ff;
            fcnt_ff    <= nxt_fcnt;
        end
    end

    // Bit 0 is SCL, bit 1 is SDA
    logic scl_f, sda_f, s_rise, s_fall, start_ev, stop_ev;
    assign scl_f    = filt_ff[0];
    assign sda_f    = filt_ff[1];
    assign s_rise   = scl_f && !prev_ff[0];
    assign s_fall   = !scl_f && prev_ff[0];
    // Conditions need SCL high in both samples so a clock edge is never mistaken
    assign start_ev = scl_f && prev_ff[0] && !sda_f && prev_ff[1];
    assign stop_ev  = scl_f && prev_ff[0] && sda_f && !prev_ff[1];

    // ***************************************************************
    // Address latch and result register
    // ***************************************************************
    logic [6:0]  addr_ff, nxt_addr;
    logic [2:0]  pend_ff;  // Straps reach s2_ff only two edges after release
    logic [11:0] temp_ff, nxt_temp;
    logic [17:0] ctime_ff, nxt_ctime;
    logic [1:0]  res;
    logic [11:0] sat;

    assign res = {resolution_sel_upper, resolution_sel_lower};

    always_comb begin
        nxt_addr = addr_ff;
        if (pend_ff[2] || start_ev || addr_acquire_req)
            nxt_addr = addr_of(s2_ff[5:4], s2_ff[3:2], s2_ff[1:0]);
        if ($signed(conv_data) > $signed(16'(tsi_pkg::TEMP_MAX)))
            sat = tsi_pkg::TEMP_MAX;
        else if ($signed(conv_data) < -$signed(16'h0800))
            sat = tsi_pkg::TEMP_MIN;
        else
            sat = conv_data[11:0];
        nxt_temp = conv_done ? (sat & res_mask(res)) : temp_ff;
        case (res)
            2'b00:   nxt_ctime = tsi_pkg::TCONV9_US;
            2'b01:   nxt_ctime = tsi_pkg::TCONV10_US;
            2'b10:   nxt_ctime = tsi_pkg::TCONV11_US;
            default: nxt_ctime = tsi_pkg::TCONV12_US;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_ff  <= {tsi_pkg::ADDR_PFX2, 3'h0};
            pend_ff  <= 3'h7;
            temp_ff  <= tsi_pkg::TEMP_RST;
            ctime_ff <= tsi_pkg::TCONV12_US;
        end else begin
            addr_ff  <= nxt_addr;
            pend_ff  <= {pend_ff[1:0], 1'b0};
            temp_ff  <= nxt_temp;
            ctime_ff <= nxt_ctime;
        end
    end

    // ***************************************************************
    // Protocol engine
    // ***************************************************************
    tsi_pkg::tsi_state_t st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh, tx_ff, nxt_tx, ptr_ff, nxt_ptr;
    logic       rw_ff, nxt_rw, ptrw_ff, nxt_ptrw, bidx_ff, nxt_bidx, oe_ff, nxt_oe;

    // Only the result register is readable here; other pointers return zero
    function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic b, input logic [11:0] t);
        if (p != tsi_pkg::PTR_TEMP)
            return 8'h00;
        return b ? {t[3:0], 4'h0} : t[11:4];
    endfunction

    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_sh   = sh_ff;
        nxt_tx   = tx_ff;
        nxt_ptr  = ptr_ff;
        nxt_rw   = rw_ff;
        nxt_ptrw = ptrw_ff;
        nxt_bidx = bidx_ff;
        if (start_ev) begin
            nxt_st  = tsi_pkg::TSI_ADDR;
            nxt_cnt = 4'h0;
        end else if (stop_ev) begin
            nxt_st = tsi_pkg::TSI_IDLE;
        end else begin
            case (st_ff)
                tsi_pkg::TSI_ADDR, tsi_pkg::TSI_WR: begin
                    if (s_rise) begin
                        nxt_sh  = {sh_ff[6:0], sda_f};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (s_fall && cnt_ff == 4'h8) begin
                        if (st_ff == tsi_pkg::TSI_WR) begin
                            nxt_st = tsi_pkg::TSI_ACK_WR;
                            if (ptrw_ff) begin
                                nxt_ptr  = sh_ff;
                                nxt_ptrw = 1'b0;
                            end
                        end else if (sh_ff[7:1] == addr_ff) begin
                            nxt_st   = tsi_pkg::TSI_ACK_AD;
                            nxt_rw   = sh_ff[0];
                            nxt_ptrw = !sh_ff[0];
                        end else begin
                            nxt_st = tsi_pkg::TSI_IDLE;
                        end
                    end
                end
                tsi_pkg::TSI_ACK_AD, tsi_pkg::TSI_ACK_WR: begin
                    if (s_fall) begin
                        nxt_cnt = 4'h0;
                        if (st_ff == tsi_pkg::TSI_ACK_AD && rw_ff) begin
                            nxt_st   = tsi_pkg::TSI_RD;
                            nxt_bidx = 1'b1;
                            nxt_tx   = rd_byte(ptr_ff, 1'b0, temp_ff);
                        end else begin
                            nxt_st = tsi_pkg::TSI_WR;
                        end
                    end
                end
                tsi_pkg::TSI_RD: begin
                    if (s_rise)
                        nxt_cnt = cnt_ff + 4'h1;
                    else if (s_fall && cnt_ff == 4'h8)
                        nxt_st = tsi_pkg::TSI_MACK;
                    else if (s_fall)
                        nxt_tx = {tx_ff[6:0], 1'b0};
                end
                tsi_pkg::TSI_MACK: begin
                    if (s_rise && sda_f) begin
                        nxt_st = tsi_pkg::TSI_IDLE;
                    end else if (s_fall) begin
                        nxt_st   = tsi_pkg::TSI_RD;
                        nxt_cnt  = 4'h0;
                        nxt_tx   = rd_byte(ptr_ff, bidx_ff, temp_ff);
                        nxt_bidx = !bidx_ff;
                    end
                end
                default: nxt_st = tsi_pkg::TSI_IDLE;
            endcase
        end
        // SDA only ever pulled low; SCL has no driver at all
        nxt_oe = (nxt_st == tsi_pkg::TSI_ACK_AD) || (nxt_st == tsi_pkg::TSI_ACK_WR) ||
                 (nxt_st == tsi_pkg::TSI_RD && !nxt_tx[7]);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff   <= tsi_pkg::TSI_IDLE;
            cnt_ff  <= 4'h0;
            sh_ff   <= 8'h00;
            tx_ff   <= 8'h00;
            ptr_ff  <= tsi_pkg::PTR_RST;
            rw_ff   <= 1'b0;
            ptrw_ff <= 1'b0;
            bidx_ff <= 1'b0;
            oe_ff   <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            sh_ff   <= nxt_sh;
            tx_ff   <= nxt_tx;
            ptr_ff  <= nxt_ptr;
            rw_ff   <= nxt_rw;
            ptrw_ff <= nxt_ptrw;
            bidx_ff <= nxt_bidx;
            oe_ff   <= nxt_oe;
        end
    end

    assign sda_o        = 1'b0;
    assign sda_oe       = oe_ff;
    assign conv_time_us = ctime_ff;
    assign temp_result  = temp_ff;
    assign reg_pointer  = ptr_ff;
    assign slave_addr   = addr_ff;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    logic seen_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            seen_ff <= 1'b0;
        else if (conv_done)
            seen_ff <= 1'b1;
    end

    property p_zero_until_conv;
        !seen_ff |-> temp_ff == 12'h000;
    endproperty
    a_zero_until_conv: assert property (p_zero_until_conv) else $error("result not zero before first conversion");
    property p_sat_mask;
        conv_done && $signed(conv_data) > 16'sh07FF |=> temp_ff == (12'h7FF & res_mask($past(res)));
    endproperty
    a_sat_mask: assert property (p_sat_mask) else $error("positive saturation wrong");
    property p_low_bits;
        conv_done && res == 2'b00 |=> temp_ff[2:0] == 3'h0;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("unused low bits not zero");
    property p_start;
        start_ev |=> st_ff == tsi_pkg::TSI_ADDR && cnt_ff == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_stop;
        stop_ev |=> st_ff == tsi_pkg::TSI_IDLE ##1 !sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not release bus");
    property p_nomatch;
        st_ff == tsi_pkg::TSI_ADDR && s_fall && cnt_ff == 4'h8 && sh_ff[7:1] != addr_ff && !start_ev && !stop_ev
            |=> st_ff == tsi_pkg::TSI_IDLE && !sda_oe;
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("responded to foreign address");
    property p_ptr_hold;
        st_ff == tsi_pkg::TSI_RD || st_ff == tsi_pkg::TSI_MACK |-> $stable(ptr_ff);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed during read");
    property p_addr_latch;
        start_ev |=> addr_ff == addr_of($past(s2_ff[5:4]), $past(s2_ff[3:2]), $past(s2_ff[1:0]));
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not latched at start");
    property p_msb_first;
        $rose(st_ff == tsi_pkg::TSI_RD) && ptr_ff == tsi_pkg::PTR_TEMP && !bidx_ff == 1'b0
            |-> sda_oe == !temp_ff[11];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first read bit not result msb");

    c_addr_ack: cover property (st_ff == tsi_pkg::TSI_ACK_AD ##1 st_ff == tsi_pkg::TSI_ACK_AD);
    c_ptr_write: cover property (st_ff == tsi_pkg::TSI_ACK_WR && ptr_ff == tsi_pkg::PTR_TEMP);
    c_read_two: cover property (st_ff == tsi_pkg::TSI_MACK && !bidx_ff);
endmodule

// ---- test/tsi_bus_master.sv ----
/*
 Bus master model: drives SCL and pulls SDA low for START, STOP and bytes.
 Assumes a pull-up on SDA outside it; the bench calls its tasks by hierarchy.
*/
module tsi_bus_master (
    // Bus lines
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Bit timing: 80 ns period, SCL idles high
    // ****************************************
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // SDA moves 15 ns into SCL low, so the slave never sees a false condition
    task automatic bit_io(input logic b, output logic r);
        #15 sda_pull = !b;
        #35 scl = 1'b1;
        #15 r = sda;
        #15 scl = 1'b0;
    endtask

    // Also serves as repeated START
    task automatic start_cond();
        #15 sda_pull = 1'b0;
        #35 scl = 1'b1;
        #15 sda_pull = 1'b1;
        #15 scl = 1'b0;
    endtask

    task automatic stop_cond();
        #15 sda_pull = 1'b1;
        #35 scl = 1'b1;
        #15 sda_pull = 1'b0;
        #15;
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!mack, r);
    endtask
endmodule

// ---- test/test_tsi_slave.sv ----
/*
 Self-checking bench for the temperature sensor two-wire slave.
 Assumes the bus master model and a pull-up on SDA; straps settle before traffic.
*/
module test_tsi_slave;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic        mclk      = 1'b0;
    logic        nrst      = 1'b0;
    logic        scl;
    logic        m_pull;
    wire         sda;
    logic        sda_o;
    logic        sda_oe;
    logic [1:0]  a_low     = 2'h0;
    logic [1:0]  a_mid     = 2'h0;
    logic [1:0]  a_high    = 2'h0;
    logic        acq       = 1'b0;
    logic        res_up    = 1'b1;
    logic        res_lo    = 1'b1;
    logic        conv_done = 1'b0;
    logic [15:0] conv_data = 16'h0000;
    logic [17:0] conv_time_us;
    logic [11:0] temp_result;
    logic [7:0]  reg_pointer;
    logic [6:0]  slave_addr;
    logic [6:0]  addr_two;
    int          n_fail    = 0;
    int          checked   = 0;
    int          oe_cnt    = 0;
    logic        ack;
    logic [7:0]  rd;

    // Open drain with pull-up: high unless someone pulls
    assign sda = !(m_pull || (sda_oe && !sda_o));

    always #2.5 mclk = ~mclk;

    always @(posedge mclk) begin
        if (sda_oe === 1'b1) begin
            oe_cnt++;
        end
    end

    tsi_bus_master i_tsi_bus_master (.scl(scl), .sda_pull(m_pull), .sda(sda));

    tsi_slave i_tsi_slave (
        .mclk(mclk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .addr_select_pin_low(a_low), .addr_select_pin_mid(a_mid), .addr_select_pin_high(a_high),
        .addr_acquire_req(acq), .resolution_sel_upper(res_up), .resolution_sel_lower(res_lo),
        .conv_done(conv_done), .conv_data(conv_data), .conv_time_us(conv_time_us),
        .temp_result(temp_result), .reg_pointer(reg_pointer), .slave_addr(slave_addr)
    );

    // Two-level variant watches the same bus; only its latched address is judged
    tsi_slave #(.THREE_LEVEL(1'b0)) i_tsi_slave_two (
        .mclk(mclk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(),
        .addr_select_pin_low(a_low), .addr_select_pin_mid(a_mid), .addr_select_pin_high(a_high),
        .addr_acquire_req(acq), .resolution_sel_upper(res_up), .resolution_sel_lower(res_lo),
        .conv_done(conv_done), .conv_data(conv_data), .conv_time_us(),
        .temp_result(), .reg_pointer(), .slave_addr(addr_two)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Straps pass a 2 FF synchroniser, so they settle before the acquire pulse
    task automatic set_straps(input logic [1:0] h, input logic [1:0] m, input logic [1:0] l, input logic pulse);
        @(posedge mclk);
        a_high <= h;
        a_mid  <= m;
        a_low  <= l;
        repeat (4) @(posedge mclk);
        acq <= pulse;
        @(posedge mclk);
        acq <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check(18'(temp_result), 18'h00000, "reset result");
        check(18'(reg_pointer), 18'h00000, "reset pointer");
        check(18'(slave_addr), 18'h00048, "reset address");
        check(conv_time_us, tsi_pkg::TCONV12_US, "reset conv time");
    endtask

    task automatic t_conv();
        logic [1:0]  rs [7] = '{2'h3, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
        logic [15:0] cd [7] = '{16'h0190, 16'h0900, 16'h0197, 16'h0197, 16'h0197, 16'hF000, 16'hFFFC};
        logic [11:0] ex [7] = '{12'h190, 12'h7FF, 12'h190, 12'h194, 12'h196, 12'h800, 12'hFFC};
        logic [17:0] tc [4] = '{tsi_pkg::TCONV9_US, tsi_pkg::TCONV10_US,
                                tsi_pkg::TCONV11_US, tsi_pkg::TCONV12_US};
        for (int i = 0; i < 7; i++) begin
            @(posedge mclk);
            res_up    <= rs[i][1];
            res_lo    <= rs[i][0];
            conv_data <= cd[i];
            conv_done <= 1'b1;
            @(posedge mclk);
            conv_done <= 1'b0;
            repeat (2) @(posedge mclk);
            #1;
            check(18'(temp_result), 18'(ex[i]), "stored result");
            check(conv_time_us, tc[rs[i]], "conv time");
        end
    endtask

    task automatic t_read();
        logic [11:0] t = 12'hFFC;
        i_tsi_bus_master.start_cond();
        i_tsi_bus_master.write_byte(8'h90, ack);
        check(18'(ack), 18'h1, "addr ack");
        i_tsi_bus_master.write_byte(8'h01, ack);
        check(18'(reg_pointer), 18'h00001, "pointer load");
        i_tsi_bus_master.write_byte(8'hA5, ack);
        check(18'(ack), 18'h1, "data ack");
        i_tsi_bus_master.stop_cond();
        check(18'(temp_result), 18'(t), "result kept");
        i_tsi_bus_master.start_cond();
        i_tsi_bus_master.write_byte(8'h91, ack);
        i_tsi_bus_master.read_byte(1'b0, rd);
        i_tsi_bus_master.stop_cond();
        check(18'(rd), 18'h00000, "other register");
        i_tsi_bus_master.start_cond();
        i_tsi_bus_master.write_byte(8'h90, ack);
        i_tsi_bus_master.write_byte(8'h00, ack);
        i_tsi_bus_master.start_cond();
        i_tsi_bus_master.write_byte(8'h91, ack);
        i_tsi_bus_master.read_byte(1'b1, rd);
        check(18'(rd), 18'(t[11:4]), "high byte");
        i_tsi_bus_master.read_byte(1'b0, rd);
        check(18'(rd), 18'({t[3:0], 4'h0}), "low byte");
        i_tsi_bus_master.stop_cond();
        check(18'(sda_oe), 18'h0, "released after nack");
        i_tsi_bus_master.start_cond();
        i_tsi_bus_master.write_byte(8'h91, ack);
        i_tsi_bus_master.read_byte(1'b0, rd);
        i_tsi_bus_master.stop_cond();
        check(18'(rd), 18'(t[11:4]), "pointer kept");
    endtask

    task automatic t_straps();
        int n;
        set_straps(2'h2, 2'h0, 2'h0, 1'b1);
        check(18'(slave_addr), 18'h00070, "top floating");
        set_straps(2'h2, 2'h2, 2'h3, 1'b0);
        i_tsi_bus_master.start_cond();
        i_tsi_bus_master.write_byte(8'h6E, ack);
        i_tsi_bus_master.write_byte(8'h00, ack);
        i_tsi_bus_master.stop_cond();
        check(18'(ack), 18'h1, "relatch at start");
        check(18'(slave_addr), 18'h00037, "all floating");
        check(18'(addr_two), 18'h00049, "two-level straps");
        n = oe_cnt;
        i_tsi_bus_master.start_cond();
        i_tsi_bus_master.write_byte(8'h90, ack);
        i_tsi_bus_master.write_byte(8'h00, ack);
        i_tsi_bus_master.stop_cond();
        check(18'(oe_cnt - n), 18'h0, "foreign address ignored");
        set_straps(2'h1, 2'h0, 2'h1, 1'b1);
        check(18'(slave_addr), 18'h0004D, "straps high");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (10) @(posedge mclk);
        #1;
        t_reset();
        t_conv();
        t_read();
        t_straps();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        n_fail++;
        $display("[FAIL] %0t run limit reached", $time);
        tally_and_finish();
    end
endmodule
